// ===== common/rsso_pkg.sv
// Purpose: Shared constants for the rotate, subtract and sleep execution block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Instruction opcodes are a field of the instruction register.
// How it works
// - Rotate left: bits move up, old carry to bit 0, bit 7 to carry.
// - Rotate right: bits move down, old carry to bit 7, bit 0 to carry.
// - Rotate destination bit 0 writes the accumulator, 1 writes the file register; literal subtract always writes the accumulator.
// - Sleep clears the power-down flag.
// - Sleep sets the time-out flag.
// - Sleep clears the watchdog count and its prescaler.
// - Sleep halts the oscillator and stops execution until woken.
// - Literal subtract writes literal minus accumulator into the accumulator.
// - Carry is set when accumulator <= literal; digit carry same on low nibbles.
package rsso_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_INSTR = 12'h000;
    localparam logic [11:0] OFF_ACC = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_WAKE = 12'h00c;
    localparam logic [11:0] OFF_WATCHDOG = 12'h010;
    localparam logic [11:0] OFF_FILE_BASE = 12'h200;
    localparam int FILE_WORDS = 128;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_DEST_BIT = 7;
    localparam int INSTR_FADDR_LSB = 8;
    localparam int INSTR_LIT_LSB = 16;
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_ASLEEP = 5;
    localparam int WAKE_BIT = 0;
    localparam int WD_PRE_LSB = 8;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_NOP = 3'h0;
    localparam logic [2:0] OP_ROTATE_LEFT_THRU_CARRY = 3'h1;
    localparam logic [2:0] OP_ROTATE_RIGHT_THRU_CARRY = 3'h2;
    localparam logic [2:0] OP_LITERAL_MINUS_ACCUMULATOR = 3'h3;
    localparam logic [2:0] OP_SLEEP = 3'h4;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic RST_POWERDOWN = 1'b1;
    localparam logic RST_TIMEOUT = 1'b1;
    localparam int WD_PRESCALE = 16;
    localparam int WD_WIDTH = 8;

    typedef enum logic {RUNNING, SLEEPING} run_mode_t;

endpackage

// ===== verilog/alu_unit.sv
// Purpose: Combinational datapath for rotate and literal subtract.
// Assumes: Operands are stable for the whole execute cycle.
// Notes: Flags not touched by an opcode are passed through unchanged.
`timescale 1ns/10ps
module alu_unit (
    // Instruction
    input wire logic [2:0] op,
    input wire logic dest,
    input wire logic [7:0] literal,
    // Operands
    input wire logic [7:0] file_val,
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic dc_in,
    input wire logic zero_in,
    // Results
    output logic [7:0] result,
    output logic carry_out,
    output logic dc_out,
    output logic zero_out,
    output logic write_acc,
    output logic write_file
);
    import rsso_pkg::*;

    logic [8:0] diff;

    // Nine-bit difference keeps the borrow for the carry flag.
    assign diff = {1'b0, literal} - {1'b0, acc};

    // Select the result and the flags for the opcode.
    always_comb begin
        result = acc;
        carry_out = carry_in;
        dc_out = dc_in;
        zero_out = zero_in;
        write_acc = 1'b0;
        write_file = 1'b0;
        unique case (op)
            OP_ROTATE_LEFT_THRU_CARRY: begin
                result = {file_val[6:0], carry_in};
                carry_out = file_val[7];
                write_acc = ~dest;
                write_file = dest;
            end
            OP_ROTATE_RIGHT_THRU_CARRY: begin
                result = {carry_in, file_val[7:1]};
                carry_out = file_val[0];
                write_acc = ~dest;
                write_file = dest;
            end
            OP_LITERAL_MINUS_ACCUMULATOR: begin
                result = diff[7:0];
                carry_out = ~diff[8];
                dc_out = (acc[3:0] <= literal[3:0]);
                zero_out = (diff[7:0] == 8'h00);
                write_acc = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule

// ===== verilog/watchdog_unit.sv
// Purpose: Watchdog counter with a prescaler.
// Assumes: Counts on pclk; a real part would count on its own oscillator.
// Notes: A clear wins over counting in the same cycle.
`timescale 1ns/10ps
module watchdog_unit #(
    parameter int PRESCALE = rsso_pkg::WD_PRESCALE,
    parameter int WIDTH = rsso_pkg::WD_WIDTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    // State
    output logic [WIDTH-1:0] count,
    output logic [7:0] prescale,
    output logic overflow
);
    import rsso_pkg::*;

    if (PRESCALE < 1 || PRESCALE > 256 || WIDTH < 1) begin : g_bad
        $error("watchdog_unit: PRESCALE must be 1..256 and WIDTH at least 1");
    end

    typedef struct packed {
        logic [7:0] pre;
        logic [WIDTH-1:0] cnt;
        logic ovf;
    } wd_state_t;

    wd_state_t st;
    wd_state_t next_st;

    localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

    // Prescaler gives one tick per PRESCALE cycles; the counter wraps.
    always_comb begin
        next_st = st;
        next_st.ovf = 1'b0;
        if (clear) begin
            next_st.pre = 8'h00;
            next_st.cnt = '0;
        end else if (st.pre == PRE_LAST) begin
            next_st.pre = 8'h00;
            next_st.cnt = st.cnt + 1'b1;
            next_st.ovf = &st.cnt;
        end else begin
            next_st.pre = st.pre + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.cnt;
    assign prescale = st.pre;
    assign overflow = st.ovf;
endmodule

// ===== verilog/rotate_subtract_sleep_ops.sv
// Purpose: APB-driven execution of rotate, literal subtract and sleep.
// Assumes: One instruction per APB write to the instruction register.
// Notes: The instruction executes at the access edge of that write.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module rotate_subtract_sleep_ops (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wake pin, asynchronous
    input wire logic wake_pin,
    // Power state
    output logic osc_run,
    output logic sleeping,
    output logic watchdog_overflow
);
    import rsso_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] acc;
        logic carry;
        logic dc;
        logic zero;
        logic powerdown_flag;
        logic timeout_flag;
        run_mode_t mode;
        logic [31:0] rdata;
        logic wake_meta;
        logic wake_sync;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    // Rotates read the file through the instruction's address, never the bus address.
    logic [7:0] file_mem [FILE_WORDS];

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // True when the address falls inside the file register window.
    function automatic logic is_file(input logic [11:0] a);
        return (a >= OFF_FILE_BASE) && (a < OFF_FILE_BASE + 12'(4 * FILE_WORDS));
    endfunction

    // True for any mapped word address.
    function automatic logic is_mapped(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (is_file(a) || a == OFF_INSTR || a == OFF_ACC ||
            a == OFF_STATUS || a == OFF_WAKE || a == OFF_WATCHDOG);
    endfunction

    logic access;
    logic wr;
    logic exec;
    logic refused;
    logic [2:0] op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] lit_val;
    logic [7:0] file_rd;
    logic [6:0] bus_faddr;
    logic file_msb;
    logic file_lsb;
    logic [7:0] alu_result;
    logic alu_carry;
    logic alu_dc;
    logic alu_zero;
    logic alu_wacc;
    logic alu_wfile;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_data;
    logic wd_clear;
    logic [WD_WIDTH-1:0] wd_count;
    logic [7:0] wd_pre;
    logic wd_ovf;
    logic wake_req;

    assign access = psel & penable;
    assign wr = access & pwrite;
    // Instruction writes while asleep are refused: the core is halted.
    assign refused = wr && paddr == OFF_INSTR && st.mode == SLEEPING;
    assign exec = wr && paddr == OFF_INSTR && st.mode == RUNNING;
    assign op = pwdata[INSTR_OP_LSB +: 3];
    assign dest = pwdata[INSTR_DEST_BIT];
    assign faddr = pwdata[INSTR_FADDR_LSB +: 7];
    assign lit_val = pwdata[INSTR_LIT_LSB +: 8];
    assign bus_faddr = 7'(paddr[8:2]);
    assign file_rd = file_mem[faddr];
    assign file_msb = file_rd[7];
    assign file_lsb = file_rd[0];

    // ------------------------------------------------------------------
    // Datapath and watchdog
    // ------------------------------------------------------------------
    alu_unit u_alu (
        .op(exec ? op : OP_NOP),
        .dest(dest),
        .literal(lit_val),
        .file_val(file_rd),
        .acc(st.acc),
        .carry_in(st.carry),
        .dc_in(st.dc),
        .zero_in(st.zero),
        .result(alu_result),
        .carry_out(alu_carry),
        .dc_out(alu_dc),
        .zero_out(alu_zero),
        .write_acc(alu_wacc),
        .write_file(alu_wfile)
    );

    // The watchdog keeps counting while asleep, so it can end a sleep with no wake source.
    assign wd_clear = exec && op == OP_SLEEP;

    watchdog_unit #(
        .PRESCALE(WD_PRESCALE),
        .WIDTH(WD_WIDTH)
    ) u_wd (
        .pclk(pclk),
        .presetn(presetn),
        .clear(wd_clear),
        .count(wd_count),
        .prescale(wd_pre),
        .overflow(wd_ovf)
    );

    // ------------------------------------------------------------------
    // File register writes
    // ------------------------------------------------------------------
    // One write port serves both the rotate result and direct bus writes.
    assign mem_we = alu_wfile | (wr & is_file(paddr));
    assign mem_addr = alu_wfile ? faddr : bus_faddr;
    assign mem_data = alu_wfile ? alu_result : pwdata[7:0];

    // The array has no reset, so it maps onto plain RAM.
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            file_mem[mem_addr] <= mem_data;
        end
    end

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    assign wake_req = st.wake_sync | (wr && paddr == OFF_WAKE && pwdata[WAKE_BIT]);

    always_comb begin
        next_st = st;
        // The first stage feeds only the second.
        next_st.wake_meta = wake_pin;
        next_st.wake_sync = st.wake_meta;
        // Read data is latched in the setup cycle for the access phase.
        if (psel && !penable) begin
            next_st.rdata = 32'h0000_0000;
            if (is_file(paddr)) begin
                next_st.rdata = {24'h00_0000, file_mem[bus_faddr]};
            end else begin
                unique case (paddr)
                    OFF_ACC: next_st.rdata = {24'h00_0000, st.acc};
                    OFF_STATUS: next_st.rdata = 32'({st.mode == SLEEPING,
                        st.timeout_flag, st.powerdown_flag, st.zero, st.dc, st.carry});
                    OFF_WATCHDOG: next_st.rdata = 32'({wd_pre, 8'(wd_count)});
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Software writes to the accumulator and the arithmetic flags.
        if (wr && paddr == OFF_ACC) begin
            next_st.acc = pwdata[7:0];
        end
        if (wr && paddr == OFF_STATUS) begin
            next_st.carry = pwdata[ST_CARRY];
            next_st.dc = pwdata[ST_DIGIT];
            next_st.zero = pwdata[ST_ZERO];
        end
        // Instruction results.
        if (alu_wacc) begin
            next_st.acc = alu_result;
        end
        if (exec) begin
            next_st.carry = alu_carry;
            next_st.dc = alu_dc;
            next_st.zero = alu_zero;
        end
        // Sleep entry and wake-up.
        unique case (st.mode)
            RUNNING: begin
                if (exec && op == OP_SLEEP) begin
                    next_st.powerdown_flag = 1'b0;
                    next_st.timeout_flag = 1'b1;
                    next_st.mode = SLEEPING;
                end
            end
            SLEEPING: begin
                // A watchdog overflow wakes the core and records the time-out.
                if (wd_ovf) begin
                    next_st.timeout_flag = 1'b0;
                    next_st.mode = RUNNING;
                end else if (wake_req) begin
                    next_st.mode = RUNNING;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{acc: RST_ACC, carry: 1'b0, dc: 1'b0, zero: 1'b0,
                powerdown_flag: RST_POWERDOWN, timeout_flag: RST_TIMEOUT,
                mode: RUNNING, rdata: 32'h0000_0000, wake_meta: 1'b0, wake_sync: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: every transfer ends at its first access edge.
    // Each instruction completes at that edge, so a wait state would only cost time.
    assign pready = 1'b1;
    assign pslverr = access & (~is_mapped(paddr) | refused);
    assign prdata = st.rdata;
    assign osc_run = (st.mode == RUNNING);
    assign sleeping = (st.mode == SLEEPING);
    assign watchdog_overflow = wd_ovf;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rotl_value: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_ROTATE_LEFT_THRU_CARRY |-> alu_result == {file_rd[6:0], st.carry})
        else $error("rotate left result wrong");
    a_rotl_flags: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_ROTATE_LEFT_THRU_CARRY |=> st.carry == $past(file_msb)
        && st.zero == $past(st.zero) && st.dc == $past(st.dc))
        else $error("rotate left flags wrong");
    a_rotr_value: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_ROTATE_RIGHT_THRU_CARRY |-> alu_result == {st.carry, file_rd[7:1]})
        else $error("rotate right result wrong");
    a_rotr_flags: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_ROTATE_RIGHT_THRU_CARRY |=> st.carry == $past(file_lsb)
        && st.zero == $past(st.zero) && st.dc == $past(st.dc))
        else $error("rotate right flags wrong");
    a_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
        exec && !dest && (op == OP_ROTATE_LEFT_THRU_CARRY || op == OP_ROTATE_RIGHT_THRU_CARRY)
        |-> !mem_we ##1 st.acc == $past(alu_result))
        else $error("rotate to accumulator wrong");
    a_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
        exec && dest && (op == OP_ROTATE_LEFT_THRU_CARRY || op == OP_ROTATE_RIGHT_THRU_CARRY)
        |-> mem_we && mem_addr == faddr ##1 st.acc == $past(st.acc))
        else $error("rotate to file register wrong");
    a_sleep_powerdown: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_SLEEP |=> !st.powerdown_flag)
        else $error("sleep left power-down flag set");
    a_sleep_timeout: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_SLEEP |=> st.timeout_flag)
        else $error("sleep left time-out flag clear");
    a_sleep_watchdog: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_SLEEP |=> wd_count == '0 && wd_pre == 8'h00)
        else $error("sleep did not clear the watchdog");
    a_sleep_halt: assert property (@(posedge pclk) disable iff (!presetn)
        sleeping && wr && paddr == OFF_INSTR |-> pslverr && !alu_wacc && !osc_run
        ##1 st.carry == $past(st.carry))
        else $error("instruction ran while asleep");
    a_sub_value: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_LITERAL_MINUS_ACCUMULATOR |=> st.acc == 8'($past(lit_val) - $past(st.acc)))
        else $error("literal subtract result wrong");
    a_sub_carry: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_LITERAL_MINUS_ACCUMULATOR |-> alu_carry == (st.acc <= lit_val)
        && alu_dc == (st.acc[3:0] <= lit_val[3:0]))
        else $error("literal subtract carry wrong");
    a_sub_zero: assert property (@(posedge pclk) disable iff (!presetn)
        exec && op == OP_LITERAL_MINUS_ACCUMULATOR |=> st.zero == (st.acc == 8'h00))
        else $error("literal subtract zero flag wrong");

    // Wake-up paths, refused instructions and single-cycle rotate completion.
    // A refused instruction must leave every register as it was.
    a_wd_wake: assert property (@(posedge pclk) disable iff (!presetn)
        sleeping && wd_ovf |=> !sleeping && !st.timeout_flag)
        else $error("watchdog overflow did not wake the core");
    a_wake_sync: assert property (@(posedge pclk) disable iff (!presetn)
        sleeping && st.wake_sync |=> !sleeping)
        else $error("synchronised wake pin ignored");
    a_halt_file: assert property (@(posedge pclk) disable iff (!presetn)
        refused |-> !mem_we && !alu_wacc)
        else $error("refused instruction wrote a register");
    a_rot_file: assert property (@(posedge pclk) disable iff (!presetn)
        exec && dest && (op == OP_ROTATE_LEFT_THRU_CARRY || op == OP_ROTATE_RIGHT_THRU_CARRY)
        |=> file_mem[$past(faddr)] == $past(alu_result))
        else $error("rotate did not finish in one cycle");
endmodule

// ===== tb/rotate_subtract_sleep_ops_tb_top.sv
// Purpose: Self-checking bench for the rotate, literal subtract and sleep block.
// Assumes: Zero-wait APB slave; instruction executes at the access edge of its write.
// Notes: Seeded random operands mixed with hand-picked corners; flags are modelled here.
`timescale 1ns/10ps
module rotate_subtract_sleep_ops_tb_top;
    import rsso_pkg::*;

    // ------------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wake_pin = 1'b0;
    logic osc_run;
    logic sleeping;
    logic watchdog_overflow;
    int err_total = 0;
    int samples_checked = 0;

    // Half period of 5 ns gives the 100 MHz bus clock.
    always #5 pclk = ~pclk;

    rotate_subtract_sleep_ops i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_pin(wake_pin), .osc_run(osc_run), .sleeping(sleeping),
        .watchdog_overflow(watchdog_overflow)
    );

    // ------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------
    // Case inequality so that an unknown read never passes as a match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Holds the request until pready is seen high, so a slow slave is served too.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin
            err_total++;
            $display("BAD t=%0t bus answer never came", $time);
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, exp, what);
    endtask

    // ------------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------------
    // Returns the new carry above the 8-bit rotated value.
    function automatic logic [8:0] rot(input logic left, input logic [7:0] v, input logic c);
        return left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
    endfunction

    // Returns zero, digit carry, carry, then the difference.
    function automatic logic [10:0] sub(input logic [7:0] k, input logic [7:0] a);
        logic [7:0] d;
        d = k - a;
        return {d == 8'h00, a[3:0] <= k[3:0], a <= k, d};
    endfunction

    function automatic logic [31:0] instr(input logic [2:0] op, input logic dest,
                                          input logic [6:0] fa, input logic [7:0] k);
        return {8'h00, k, 1'b0, fa, dest, 4'h0, op};
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] v, a, k;
        logic [6:0] fa;
        logic [2:0] fl;
        logic [8:0] rr;
        logic [10:0] sr;
        logic left, dest;
        int n;
        r = $urandom(1358);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state: accumulator clear, power-down and time-out flags high.
        rd_chk(OFF_ACC, 32'h00000000, "acc reset");
        rd_chk(OFF_STATUS, 32'h00000018, "status reset");
        $display("test reset done");

        // Rotates through carry, both directions, both destinations, corner addresses.
        for (int i = 0; i < 24; i++) begin
            fa = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($urandom);
            v = (i < 4) ? 8'he6 : 8'($urandom);
            a = 8'($urandom);
            fl = 3'($urandom);
            left = i[0];
            dest = i[1];
            wr(OFF_FILE_BASE + {3'b000, fa, 2'b00}, {24'h000000, v});
            wr(OFF_ACC, {24'h000000, a});
            wr(OFF_STATUS, {29'h0, fl});
            wr(OFF_INSTR, instr(left ? OP_ROTATE_LEFT_THRU_CARRY : OP_ROTATE_RIGHT_THRU_CARRY,
                                dest, fa, 8'($urandom)));
            rr = rot(left, v, fl[0]);
            rd_chk(OFF_ACC, {24'h0, dest ? a : rr[7:0]}, "rotate acc");
            rd_chk(OFF_FILE_BASE + {3'b000, fa, 2'b00}, {24'h0, dest ? rr[7:0] : v},
                   "rotate file");
            rd_chk(OFF_STATUS, {26'h0, 3'b011, fl[2:1], rr[8]}, "rotate flags");
        end
        $display("test rotate done");

        // Literal minus accumulator: equal, zero, borrow and nibble-borrow corners first.
        for (int i = 0; i < 20; i++) begin
            k = (i == 0) ? 8'h00 : (i == 2) ? 8'h00 : (i == 3) ? 8'h17 : 8'($urandom);
            a = (i == 0) ? 8'h00 : (i == 1) ? k : (i == 2) ? 8'hff : (i == 3) ? 8'h08 :
                8'($urandom);
            fl = 3'($urandom);
            wr(OFF_ACC, {24'h000000, a});
            wr(OFF_STATUS, {29'h0, fl});
            wr(OFF_INSTR, instr(OP_LITERAL_MINUS_ACCUMULATOR, 1'($urandom), 7'($urandom), k));
            sr = sub(k, a);
            rd_chk(OFF_ACC, {24'h0, sr[7:0]}, "subtract result");
            rd_chk(OFF_STATUS, {26'h0, 3'b011, sr[10], sr[9], sr[8]},
                   "subtract flags");
        end
        $display("test subtract done");

        // Sleep, then a refused instruction, then wake through the register.
        repeat (40) @(posedge pclk);
        // Arithmetic flags are cleared so that the status words below are known.
        wr(OFF_ACC, 32'h0000005a);
        wr(OFF_STATUS, 32'h00000000);
        wr(OFF_INSTR, instr(OP_SLEEP, 1'b0, 7'h00, 8'h00));
        @(negedge pclk);
        chk({30'h0, sleeping, osc_run}, 32'h00000002, "sleep state");
        apb(1'b0, OFF_WATCHDOG, 32'h0, r, e);
        chk({31'h0, r[7:0] === 8'h00 && r[15:8] < 8'h04}, 32'h1,
            "watchdog cleared");
        rd_chk(OFF_STATUS, 32'h00000030, "sleep flags");
        apb(1'b1, OFF_INSTR, instr(OP_ROTATE_LEFT_THRU_CARRY, 1'b0, 7'h00, 8'h00), r, e);
        chk({31'h0, e}, 32'h1, "instr while asleep refused");
        rd_chk(OFF_ACC, 32'h0000005a, "acc kept while asleep");
        wr(OFF_WAKE, 32'h00000001);
        @(negedge pclk);
        chk({30'h0, sleeping, osc_run}, 32'h00000001, "woken by register");
        $display("test sleep done");

        // Sleep again and leave it by the asynchronous pin.
        wr(OFF_INSTR, instr(OP_SLEEP, 1'b0, 7'h00, 8'h00));
        @(negedge pclk);
        chk({30'h0, sleeping, osc_run}, 32'h00000002, "second sleep");
        @(posedge pclk);
        wake_pin <= 1'b1;
        n = 0;
        while (sleeping !== 1'b0 && n < 10) begin
            n++;
            @(posedge pclk);
        end
        chk({31'h0, n < 10}, 32'h1, "woken by pin");
        wake_pin <= 1'b0;
        $display("test wake pin done");

        // Unmapped and misaligned reads are refused and return zero.
        apb(1'b0, 12'h100, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000, "unmapped read");
        apb(1'b0, 12'h006, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000, "misaligned read");
        $display("test unmapped done");

        // Sleep with no wake source: the watchdog overflow ends it and clears time-out.
        wr(OFF_INSTR, instr(OP_SLEEP, 1'b0, 7'h00, 8'h00));
        n = 0;
        while (watchdog_overflow !== 1'b1 && n < 5000) begin
            n++;
            @(posedge pclk);
        end
        chk(n, WD_PRESCALE * (1 << WD_WIDTH) + 1, "watchdog period");
        @(negedge pclk);
        chk({29'h0, watchdog_overflow, sleeping, osc_run}, 32'h1, "watchdog wake");
        rd_chk(OFF_STATUS, 32'h00000000, "flags after watchdog wake");
        wr(OFF_INSTR, instr(OP_SLEEP, 1'b0, 7'h00, 8'h00));
        rd_chk(OFF_STATUS, 32'h00000030, "time-out set again");
        wr(OFF_WAKE, 32'h00000001);
        $display("test watchdog done");
        results();
    end
endmodule
